/* File: inc/lcd_core_regs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the LCD core
// Assumes: 40 MHz system clock, 8-bit register port
// Notes:   Included by the core and by the bench
`ifndef LCD_CORE_REGS_SVH
`define LCD_CORE_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_PTR 3'h0
`define REG_DATA 3'h1
`define REG_MODE 3'h2
`define REG_VADJ 3'h3
`define REG_STATUS 3'h4

// ****************************************
// Mode fields
// ****************************************
`define MODE_OSC_ON 0
`define MODE_BIAS_ON 1
`define MODE_DISP_ON 2
`define MODE_HALF_BIAS 3
`define MODE_FAST_FRAME 4
`define MODE_BLINK_LO 5
`define MODE_BLINK_HI 6

// ****************************************
// Supply adjust fields
// ****************************************
`define VADJ_STEP_HI 3
`define VADJ_ADJ_OFF 4
`define VADJ_DETECT 5

// ****************************************
// Reset values and sizes
// ****************************************
`define MODE_RESET 8'h00
`define VADJ_RESET 8'h00
`define RAM_LAST_ADDR 5'h15
`define SEG_COUNT 44

// ****************************************
// Timing
// ****************************************
`define CLOCK_HZ 40000000
`define SYS_OSC_HZ 32000
`define SYS_TICK_CYC (`CLOCK_HZ / `SYS_OSC_HZ)
`define POR_IDLE_CYC (`CLOCK_HZ / 1000)
`define FRAME_SLOW_HZ 80
`define FRAME_FAST_HZ 160
`define HALF_PHASES 8
`define HALF_SLOW_TICKS (`SYS_OSC_HZ / (`FRAME_SLOW_HZ * `HALF_PHASES))
`define HALF_FAST_TICKS (`SYS_OSC_HZ / (`FRAME_FAST_HZ * `HALF_PHASES))
`define BLINK_MODE1_BIT 13
`define BLINK_MODE2_BIT 14
`define BLINK_MODE3_BIT 15

`endif

/* File: inc/lcd_core_pkg.sv */
// Purpose: Types shared by the LCD core
// Assumes: Nothing
// Notes:   Level codes index the bias ladder from ground to supply
package lcd_core_pkg;

   typedef enum logic [1:0] {
      LVL_VSS = 2'h0,
      LVL_LOW = 2'h1,
      LVL_HIGH = 2'h2,
      LVL_LCD_SUPPLY_LEVEL_PIN = 2'h3
   } level_e;

   // Gray order along the scan
   typedef enum logic [1:0] {
      PH_COMMON_OUTPUT_FIRST = 2'h0,
      PH_COM1 = 2'h1,
      PH_COM2 = 2'h3,
      PH_COMMON_OUTPUT_FOURTH = 2'h2
   } phase_e;

   typedef logic [21:0][7:0] ram_t;

endpackage

/* File: hw/sys_osc_tick.sv */
// Purpose: Internal system oscillator, modelled as a tick divided from CLOCK
// Assumes: CLOCK at 40 MHz
// Notes:   Stopped oscillator gives no ticks and restarts its count
`timescale 1ns/1ps
`include "lcd_core_regs.svh"

module sys_osc_tick (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic run,
   output logic tick
);

   typedef struct packed {
      logic [10:0] cnt;
      logic tick;
   } osc_s;

   localparam logic [10:0] LAST = 11'(`SYS_TICK_CYC - 1);

   osc_s s;
   osc_s next_s;

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (!run) begin
         next_s.cnt = '0;
      end else if (s.cnt == LAST) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + 11'h001;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;

endmodule // sys_osc_tick

/* File: hw/segment_lcd_display_core.sv */
// Purpose: Display RAM, scan timing and drive-level generation of a 44x4 LCD driver
// Assumes: Register port on CLOCK; glass driven through level codes per pin
// Notes:   Each pin output is a 2-bit ladder tap code, decoded by the analog drivers
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "lcd_core_regs.svh"

// How it works
// - After reset every common and segment pin sits at supply level.
// - Reset selects quarter duty with one-third bias.
// - Reset leaves oscillator, bias generator and display off; no waveforms.
// - Reset enables supply adjustment and disables the supply-pin detect switch.
// - Reset selects the 80 Hz frame and blinking off.
// - Display held in 44 by 4 bits; one means segment on.
// - RAM column k feeds all segments while common k is active.
// - Byte n holds segment 2n low nibble, 2n+1 high nibble, bit k common k.
// - All scan and frame timing comes from the internal oscillator.
// - Half bias bypasses the centre divider element; third bias keeps all three.
// - 44 segment outputs formed from common phase and latched RAM bit.
// - Four common outputs follow the selected duty and bias.
// - Pointer is set first, then one or more data bytes are stored there.
// - Pointer advances by one per data byte, wrapping from last to zero.
module segment_lcd_display_core
   import lcd_core_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic [87:0] SEGMENT_OUTPUT,
   output logic [7:0] COMMON_OUTPUT,
   output logic BIAS_GEN_ON,
   output logic BIAS_CENTRE_BYPASS,
   output logic SUPPLY_ADJUST_EN,
   output logic [3:0] SUPPLY_ADJUST_STEP,
   output logic LCD_SUPPLY_LEVEL_PIN_DETECT_EN
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      ram_t ram;
      logic [43:0] latch;
      logic [4:0] ptr;
      logic osc_on;
      logic bias_on;
      logic disp_on;
      logic half_bias;
      logic fast_frame;
      logic [1:0] blink;
      logic [3:0] step;
      logic adj_en;
      logic detect_en;
      phase_e phase;
      logic half;
      logic [5:0] sub_cnt;
      logic [15:0] blink_cnt;
      logic [7:0] rdata;
      logic [87:0] seg_lvl;
      logic [7:0] com_lvl;
   } core_s;

   core_s s;
   core_s next_s;
   logic osc_tick;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [4:0] ptr_step(input logic [4:0] p);
      ptr_step = (p == `RAM_LAST_ADDR) ? 5'h00 : p + 5'h01;
   endfunction

   function automatic logic [4:0] ptr_load(input logic [7:0] v);
      // Out-of-range values land on zero so the pointer stays inside RAM
      ptr_load = (v[7:5] == 3'h0 && v[4:0] <= `RAM_LAST_ADDR) ? v[4:0] : 5'h00;
   endfunction

   function automatic logic [1:0] col_of(input phase_e ph);
      unique case (ph)
         PH_COMMON_OUTPUT_FIRST: col_of = 2'h0;
         PH_COM1: col_of = 2'h1;
         PH_COM2: col_of = 2'h2;
         PH_COMMON_OUTPUT_FOURTH: col_of = 2'h3;
      endcase
   endfunction

   function automatic phase_e phase_step(input phase_e ph);
      unique case (ph)
         PH_COMMON_OUTPUT_FIRST: phase_step = PH_COM1;
         PH_COM1: phase_step = PH_COM2;
         PH_COM2: phase_step = PH_COMMON_OUTPUT_FOURTH;
         PH_COMMON_OUTPUT_FOURTH: phase_step = PH_COMMON_OUTPUT_FIRST;
      endcase
   endfunction

   function automatic logic seg_bit(input ram_t r, input int seg, input logic [1:0] col);
      logic [7:0] b;
      b = r[seg / 2];
      seg_bit = (seg % 2 == 0) ? b[col] : b[3'(col) + 3'h4];
   endfunction

   function automatic logic [43:0] column_bits(input ram_t r, input logic [1:0] col);
      column_bits = '0;
      for (int n = 0; n < `SEG_COUNT; n++) begin
         column_bits[n] = seg_bit(r, n, col);
      end
   endfunction

   // Blink blanks the glass while the chosen counter bit is high
   function automatic logic dark_now(input core_s c);
      unique case (c.blink)
         2'h0: dark_now = 1'b0;
         2'h1: dark_now = c.blink_cnt[`BLINK_MODE1_BIT];
         2'h2: dark_now = c.blink_cnt[`BLINK_MODE2_BIT];
         2'h3: dark_now = c.blink_cnt[`BLINK_MODE3_BIT];
      endcase
   endfunction

   // ****************************************
   // Oscillator
   // ****************************************
   sys_osc_tick osc (
      .clock(CLOCK),
      .rst_b(RST_B),
      .run(s.osc_on),
      .tick(osc_tick)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [5:0] half_last;
      logic [1:0] col;
      logic live;
      logic dark;
      logic on;
      level_e lvl;
      half_last = 6'h00;
      col = 2'h0;
      live = 1'b0;
      dark = 1'b0;
      on = 1'b0;
      lvl = LVL_LCD_SUPPLY_LEVEL_PIN;
      next_s = s;
      next_s.rdata = 8'h00;

      // Register writes
      if (WR) begin
         unique case (ADDR)
            `REG_PTR: begin
               next_s.ptr = ptr_load(WDATA);
            end
            `REG_DATA: begin
               next_s.ram[s.ptr] = WDATA;
               next_s.ptr = ptr_step(s.ptr);
            end
            `REG_MODE: begin
               next_s.osc_on = WDATA[`MODE_OSC_ON];
               next_s.bias_on = WDATA[`MODE_BIAS_ON];
               next_s.disp_on = WDATA[`MODE_DISP_ON];
               next_s.half_bias = WDATA[`MODE_HALF_BIAS];
               next_s.fast_frame = WDATA[`MODE_FAST_FRAME];
               next_s.blink = WDATA[`MODE_BLINK_HI:`MODE_BLINK_LO];
            end
            `REG_VADJ: begin
               next_s.step = WDATA[`VADJ_STEP_HI:0];
               next_s.adj_en = !WDATA[`VADJ_ADJ_OFF];
               next_s.detect_en = WDATA[`VADJ_DETECT];
            end
            default: begin
            end
         endcase
      end

      // Register reads, data valid the cycle after the strobe only
      if (RD) begin
         unique case (ADDR)
            `REG_PTR: begin
               next_s.rdata = {3'h0, s.ptr};
            end
            `REG_DATA: begin
               next_s.rdata = s.ram[s.ptr];
               next_s.ptr = ptr_step(s.ptr);
            end
            `REG_MODE: begin
               next_s.rdata = {1'b0, s.blink, s.fast_frame, s.half_bias,
                               s.disp_on, s.bias_on, s.osc_on};
            end
            `REG_VADJ: begin
               next_s.rdata = {2'h0, s.detect_en, !s.adj_en, s.step};
            end
            `REG_STATUS: begin
               next_s.rdata = {4'h0, dark_now(s), s.half, col_of(s.phase)};
            end
            default: begin
               next_s.rdata = 8'h00;
            end
         endcase
      end

      // Scan timing, paced only by oscillator ticks
      half_last = s.fast_frame ? 6'(`HALF_FAST_TICKS - 1) : 6'(`HALF_SLOW_TICKS - 1);
      if (!s.osc_on) begin
         next_s.sub_cnt = 6'h00;
      end else if (osc_tick) begin
         next_s.blink_cnt = s.blink_cnt + 16'h0001;
         if (s.sub_cnt >= half_last) begin
            next_s.sub_cnt = 6'h00;
            next_s.half = ~s.half;
            if (s.half) begin
               next_s.phase = phase_step(s.phase);
            end
         end else begin
            next_s.sub_cnt = s.sub_cnt + 6'h01;
         end
      end

      // Drive levels
      live = s.osc_on && s.bias_on && s.disp_on;
      dark = dark_now(s);
      col = col_of(s.phase);
      // Reload on a common change or while the display is not live, so a RAM write cannot tear a running phase
      if (!live || next_s.phase != s.phase) begin
         next_s.latch = column_bits(s.ram, col_of(next_s.phase));
      end
      for (int k = 0; k < 4; k++) begin
         if (!live) begin
            lvl = LVL_LCD_SUPPLY_LEVEL_PIN;
         end else if (2'(k) == col) begin
            lvl = s.half ? LVL_VSS : LVL_LCD_SUPPLY_LEVEL_PIN;
         end else if (s.half_bias) begin
            lvl = LVL_LOW;
         end else begin
            lvl = s.half ? LVL_HIGH : LVL_LOW;
         end
         next_s.com_lvl[2*k +: 2] = lvl;
      end
      for (int n = 0; n < `SEG_COUNT; n++) begin
         on = s.latch[n] && !dark;
         if (!live) begin
            lvl = LVL_LCD_SUPPLY_LEVEL_PIN;
         end else if (on) begin
            lvl = s.half ? LVL_LCD_SUPPLY_LEVEL_PIN : LVL_VSS;
         end else if (s.half_bias) begin
            lvl = LVL_LOW;
         end else begin
            lvl = s.half ? LVL_LOW : LVL_HIGH;
         end
         next_s.seg_lvl[2*n +: 2] = lvl;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         s <= '0;
         s.osc_on <= 1'(`MODE_RESET >> `MODE_OSC_ON);
         s.bias_on <= 1'(`MODE_RESET >> `MODE_BIAS_ON);
         s.disp_on <= 1'(`MODE_RESET >> `MODE_DISP_ON);
         s.half_bias <= 1'(`MODE_RESET >> `MODE_HALF_BIAS);
         s.fast_frame <= 1'(`MODE_RESET >> `MODE_FAST_FRAME);
         s.blink <= 2'(`MODE_RESET >> `MODE_BLINK_LO);
         s.step <= 4'(`VADJ_RESET);
         s.adj_en <= !1'(`VADJ_RESET >> `VADJ_ADJ_OFF);
         s.detect_en <= 1'(`VADJ_RESET >> `VADJ_DETECT);
         s.phase <= PH_COMMON_OUTPUT_FIRST;
         s.seg_lvl <= {44{LVL_LCD_SUPPLY_LEVEL_PIN}};
         s.com_lvl <= {4{LVL_LCD_SUPPLY_LEVEL_PIN}};
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign RDATA = s.rdata;
   assign SEGMENT_OUTPUT = s.seg_lvl;
   assign COMMON_OUTPUT = s.com_lvl;
   assign BIAS_GEN_ON = s.bias_on;
   assign BIAS_CENTRE_BYPASS = s.half_bias;
   assign SUPPLY_ADJUST_EN = s.adj_en;
   assign SUPPLY_ADJUST_STEP = s.step;
   assign LCD_SUPPLY_LEVEL_PIN_DETECT_EN = s.detect_en;

endmodule // segment_lcd_display_core

/* File: testbench/lcd_core_props.sv */
// Purpose: Port checker of the LCD core
// Assumes: Sees only the top module ports
// Notes:   Bound to the core at the foot of this file
`timescale 1ns/1ps
module lcd_core_props (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic [87:0] SEGMENT_OUTPUT,
   input wire logic [7:0] COMMON_OUTPUT,
   input wire logic BIAS_GEN_ON,
   input wire logic BIAS_CENTRE_BYPASS,
   input wire logic SUPPLY_ADJUST_EN,
   input wire logic [3:0] SUPPLY_ADJUST_STEP,
   input wire logic LCD_SUPPLY_LEVEL_PIN_DETECT_EN
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   logic [3:0] com_low;
   logic [3:0] com_two;
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         com_low[k] = COMMON_OUTPUT[2*k +: 2] == 2'h0;
         com_two[k] = COMMON_OUTPUT[2*k +: 2] == 2'h2;
      end
   end
   reset_values_a: assert property ($rose(RST_B) |-> SEGMENT_OUTPUT == '1
      && COMMON_OUTPUT == '1 && !BIAS_GEN_ON && SUPPLY_ADJUST_EN
      && !LCD_SUPPLY_LEVEL_PIN_DETECT_EN)
      else $error("pins or config not at reset level");
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data outside its cycle");
   unmapped_read_a: assert property (RD && ADDR > 3'h4 |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   ptr_range_a: assert property (RD && ADDR == 3'h0 |=> RDATA <= 8'h15)
      else $error("pointer beyond last address");
   vadj_write_a: assert property (WR && ADDR == 3'h3 |=>
      SUPPLY_ADJUST_EN == !$past(WDATA[4])
      && SUPPLY_ADJUST_STEP == $past(WDATA[3:0])
      && LCD_SUPPLY_LEVEL_PIN_DETECT_EN == $past(WDATA[5]))
      else $error("supply adjust outputs wrong");
   mode_write_a: assert property (WR && ADDR == 3'h2 |=>
      BIAS_GEN_ON == $past(WDATA[1]) && BIAS_CENTRE_BYPASS == $past(WDATA[3]))
      else $error("bias controls wrong");
   half_bias_a: assert property (BIAS_CENTRE_BYPASS [*4] |-> !(|com_two))
      else $error("upper tap used in half bias");
   display_off_a: assert property (!BIAS_GEN_ON [*3] |->
      SEGMENT_OUTPUT == '1 && COMMON_OUTPUT == '1)
      else $error("waveform while bias is off");
   one_common_a: assert property ($countones(com_low) <= 1)
      else $error("two commons active");
   cover property (WR && ADDR == 3'h1);
   cover property (|com_low);
   cover property (BIAS_CENTRE_BYPASS && (|com_low));
endmodule // lcd_core_props

bind segment_lcd_display_core lcd_core_props chk_u (
   .CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .SEGMENT_OUTPUT(SEGMENT_OUTPUT), .COMMON_OUTPUT(COMMON_OUTPUT),
   .BIAS_GEN_ON(BIAS_GEN_ON), .BIAS_CENTRE_BYPASS(BIAS_CENTRE_BYPASS),
   .SUPPLY_ADJUST_EN(SUPPLY_ADJUST_EN), .SUPPLY_ADJUST_STEP(SUPPLY_ADJUST_STEP),
   .LCD_SUPPLY_LEVEL_PIN_DETECT_EN(LCD_SUPPLY_LEVEL_PIN_DETECT_EN)
);

/* File: testbench/lcd_glass_model.sv */
// Purpose: Glass model, reports which segments see full drive
// Assumes: Pin codes are ladder taps 0 to 3
// Notes:   Passive panel, drives nothing back
`timescale 1ns/1ps
module lcd_glass_model (
   input wire logic [87:0] seg_pins,
   input wire logic [7:0] com_pins,
   output logic [43:0] lit
);
   // ****************************************
   // Full drive detect
   // ****************************************
   int act;
   always_comb begin
      act = 0;
      for (int k = 0; k < 4; k++) begin
         if (com_pins[2*k +: 2] == 2'h0 || com_pins[2*k +: 2] == 2'h3) begin
            act = k;
         end
      end
      // Supply against ground, or the low tap against the high tap, lights a pixel
      for (int s = 0; s < 44; s++) begin
         lit[s] = (seg_pins[2*s +: 2] ^ com_pins[2*act +: 2]) == 2'h3;
      end
   end
endmodule // lcd_glass_model

/* File: testbench/tb_segment_lcd_display_core.sv */
// Purpose: Self-checking bench of the LCD core
// Assumes: 40 MHz clock; fast frame keeps the run short
// Notes:   RAM and pointer modelled with integers
`timescale 1ns/1ps
`include "lcd_core_regs.svh"
module tb_segment_lcd_display_core;
   // ****************************************
   // Bench
   // ****************************************
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata, com;
   logic [87:0] seg;
   logic bias_on, bypass, adj_en, detect;
   logic [3:0] step;
   logic [43:0] lit;
   logic [15:0] lfsr = 16'hE108;
   int n_errors = 0;
   int n_tests = 0;
   int ram [22];
   int ptr = 0;
   int cyc;
   always #12.5 clock = ~clock;
   segment_lcd_display_core dut_u (
      .CLOCK(clock), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .SEGMENT_OUTPUT(seg), .COMMON_OUTPUT(com), .BIAS_GEN_ON(bias_on),
      .BIAS_CENTRE_BYPASS(bypass), .SUPPLY_ADJUST_EN(adj_en), .SUPPLY_ADJUST_STEP(step),
      .LCD_SUPPLY_LEVEL_PIN_DETECT_EN(detect)
   );
   lcd_glass_model glass_u (.seg_pins(seg), .com_pins(com), .lit(lit));
   function automatic logic [15:0] next_rand(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(logic [87:0] seen, logic [87:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Write, then follow it in the model
   task automatic put(logic [2:0] a, logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      if (a == `REG_PTR)
         ptr = d > 21 ? 0 : int'(d);
      if (a == `REG_DATA) begin
         ram[ptr] = d;
         ptr = (ptr + 1) % 22;
      end
   endtask
   task automatic get(logic [2:0] a, logic [7:0] exp);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      check(88'(rdata), 88'(exp));
   endtask
   task automatic wait_change(logic [7:0] was, int limit, output int n);
      n = 0;
      while (com === was && n < limit) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n >= limit) begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   task automatic check_phase(int k, int h, int half);
      logic [87:0] s_exp;
      logic [43:0] l_exp;
      logic [7:0] c_exp;
      int on;
      for (int j = 0; j < 4; j++) begin
         c_exp[2*j +: 2] = j == k ? (h ? 2'h0 : 2'h3) : (half || !h ? 2'h1 : 2'h2);
      end
      for (int s = 0; s < 44; s++) begin
         on = (ram[s / 2] >> (4 * (s % 2) + k)) & 1;
         l_exp[s] = on[0];
         s_exp[2*s +: 2] = on[0] ? (h ? 2'h3 : 2'h0) : (half || h ? 2'h1 : 2'h2);
      end
      check(88'(com), 88'(c_exp));
      check(seg, s_exp);
      check(88'(lit), 88'(l_exp));
   endtask
   initial begin
      logic [7:0] d;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      #1;
      check(seg, '1);
      check(88'({com, bias_on, bypass, adj_en, step, detect}), 88'hFF20);
      repeat (`POR_IDLE_CYC) @(posedge clock);
      get(`REG_MODE, 8'h00);
      get(`REG_VADJ, 8'h00);
      put(`REG_PTR, 8'h00);
      for (int i = 0; i < 23; i++) begin
         lfsr = next_rand(lfsr);
         put(`REG_DATA, lfsr[7:0]);
      end
      get(`REG_PTR, 8'h01);
      put(`REG_PTR, 8'h14);
      for (int i = 0; i < 3; i++) begin
         get(`REG_DATA, 8'(ram[ptr]));
         ptr = (ptr + 1) % 22;
      end
      get(`REG_PTR, 8'(ptr));
      put(`REG_PTR, 8'h16);
      get(`REG_PTR, 8'h00);
      for (int a = 5; a < 8; a++) begin
         put(3'(a), 8'hFF);
         get(3'(a), 8'h00);
      end
      get(`REG_MODE, 8'h00);
      for (int i = 0; i < 4; i++) begin
         lfsr = next_rand(lfsr);
         d = {2'h0, lfsr[5:0]};
         put(`REG_VADJ, d);
         #1;
         check(88'({adj_en, step, detect}), 88'({~d[4], d[3:0], d[5]}));
      end
      put(`REG_MODE, 8'h17);
      wait_change(8'hFF, 26 * `SYS_TICK_CYC + 10, cyc);
      check_phase(0, 0, 0);
      wait_change(com, 31260, cyc);
      check_phase(0, 1, 0);
      // First half is a cycle longer while the oscillator starts, so time the second
      wait_change(com, 31260, cyc);
      check(88'(cyc), 88'(`HALF_FAST_TICKS * `SYS_TICK_CYC));
      check_phase(1, 0, 0);
      get(`REG_STATUS, 8'h01);
      put(`REG_MODE, 8'h1F);
      repeat (3) @(posedge clock);
      #1;
      check(88'(bypass), 88'h1);
      check_phase(1, 0, 1);
      put(`REG_MODE, 8'h00);
      repeat (3) @(posedge clock);
      #1;
      check(seg, '1);
      put(`REG_MODE, 8'h60);
      get(`REG_MODE, 8'h60);
      tally_and_finish();
   end
endmodule // tb_segment_lcd_display_core
